// ---- core/clock_gen_pkg.sv ----
package clock_gen_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] power_control_two_idx = 8'h02;
  localparam logic [7:0] clock_config_one_idx = 8'h06;
  localparam logic [7:0] loop_control_one_idx = 8'h3C;
  localparam logic [7:0] loop_control_two_idx = 8'h3D;
  localparam logic [7:0] loop_control_three_idx = 8'h3E;
  localparam logic [7:0] loop_control_four_idx = 8'h3F;
  localparam logic [7:0] loop_control_five_idx = 8'h40;
  localparam logic [7:0] clock_config_four_idx = 8'h42;
  localparam logic [7:0] audio_clock_ctrl_idx = 8'h50;
  localparam logic [7:0] pin_function_idx = 8'h51;
  localparam logic [7:0] status_idx = 8'h52;

  // Field positions.
  localparam int pin_clock_enable_bit = 11;
  localparam int pin_clock_divider_lsb = 9;
  localparam int timeout_clock_enable_bit = 14;
  localparam int timeout_half_rate_select_bit = 15;
  localparam int timeout_divide_sixteen_bit = 8;
  localparam int timeout_times_four_bit = 7;
  localparam int loop_enable_bit = 0;
  localparam int loop_osc_enable_bit = 1;
  localparam int loop_fractional_mode_bit = 2;
  localparam int loop_output_divider_lsb = 8;
  localparam int loop_integer_multiplier_lsb = 5;
  localparam int loop_reference_prediv_lsb = 3;
  localparam int bit_clock_divider_lsb = 0;
  localparam int frame_rate_lsb = 8;
  localparam int master_mode_bit = 15;
  localparam int external_bit_clock_bit = 14;

  // Reset values.
  localparam logic [15:0] power_control_two_rst = 16'h0000;
  localparam logic [15:0] clock_config_one_rst = 16'h01C0;
  localparam logic [15:0] clock_config_four_rst = 16'h025E;
  localparam logic [15:0] loop_control_one_rst = 16'h0000;
  localparam logic [15:0] loop_control_two_rst = 16'h0000;
  localparam logic [15:0] loop_control_three_rst = 16'h0000;
  localparam logic [15:0] loop_control_four_rst = 16'h2EE0;
  localparam logic [15:0] loop_control_five_rst = 16'h0002;
  localparam logic [15:0] audio_clock_ctrl_rst = 16'h2003;
  localparam logic [15:0] pin_function_rst = 16'h0000;

  // Timing.
  localparam int clk_hz = 25_000_000;
  localparam int internal_slow_hz = 256_000;
  localparam int slow_tick_cycles = (clk_hz + internal_slow_hz - 1) / internal_slow_hz;
  localparam int timeout_base_div = 1024;
  localparam logic [1:0] pin_func_clock = 2'h1;
  localparam logic [31:0] unmapped_data = 32'h0000_0000;

  // Tick scaling in base-rate units.
  localparam int timeout_x4_half_periods = 256;

  typedef enum logic [1:0] {
    resp_okay = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_t;

  typedef struct packed {
    logic [2:0] output_divider;
    logic [2:0] reference_ratio;
    logic [15:0] fraction_multiplier;
    logic [9:0] integer_multiplier;
    logic [1:0] reference_prediv;
    logic [1:0] reference_source;
    logic fractional_mode;
    logic osc_enable;
    logic enable;
  } loop_config_t;

endpackage

// ---- core/codec_clock_generation.sv ----
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Pin clock divider codes 0..8 give divide by 1,2,3,4,5.5,6,8,12,16.
// - Pin clock output gated by enable bit 11, reset off.
// - Pin clock reaches general pin one only when its function selects clock.
// - Timeout clock base is the 256 kHz clock divided by 1024.
// - Timeout clock runs only when its enable bit 14 is set.
// - Timeout rate bit 15 clear halves the clock, set passes it.
// - Divide-by-sixteen bit 8 divides the timeout clock by 16.
// - Times-four bit 7 multiplies timeout clock; rates span 1000 to 7.8125 Hz.
// - Master mode bit clock is system clock over bit-clock divider.
// - Master frame clock is bit clock, internal or external, over frame rate; the code divides by twice the frame rate field.
// - Loop accepts master, bit or frame clock as reference.
// - Reference prediv divides by 1,2,4,8 to reach 13.5 MHz or less.
// - Integer multiplier has LSB weight one in both modes.
// - Fraction multiplier applies only in fractional mode.
// - Fraction multiplier is unsigned with MSB weight one half.
// - Loop output is oscillator frequency over output divider.
// - Oscillator is reference times multiplier times ratio factor.
// - Loop can run free without any reference at reduced accuracy.
module codec_clock_generation (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite slave.
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External audio clock pins.
  input wire logic ext_bit_clock,
  input wire logic ext_frame_clock,
  input wire logic master_clock_in,
  // Generated clocks and loop view.
  output logic general_pin_one,
  output logic timeout_clock,
  output logic bit_clock_out,
  output logic frame_clock_out,
  output logic [15:0] osc_multiplier_int,
  output logic [15:0] osc_multiplier_frac,
  output logic [8:0] osc_total_factor_log,
  output logic [2:0] loop_reference_sel_out,
  output logic loop_reference_level,
  output var clock_gen_pkg::loop_config_t loop_config,
  output logic loop_running,
  output logic loop_free_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [15:0] pwr2_q, clk1_q, clk4_q, audio_q, pinf_q;
  logic [15:0] loop1_q, loop2_q, loop3_q, loop4_q, loop5_q;

  logic aw_got_q, w_got_q;
  logic [8:0] aw_addr_q;
  logic [15:0] w_data_q;
  logic [1:0] w_strb_q;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;

  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_hit;
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_idx = {1'b0, aw_addr_q[8:2]};

  always_comb begin
    case (wr_idx)
      clock_gen_pkg::power_control_two_idx, clock_gen_pkg::clock_config_one_idx,
      clock_gen_pkg::clock_config_four_idx, clock_gen_pkg::loop_control_one_idx,
      clock_gen_pkg::loop_control_two_idx, clock_gen_pkg::loop_control_three_idx,
      clock_gen_pkg::loop_control_four_idx, clock_gen_pkg::loop_control_five_idx,
      clock_gen_pkg::audio_clock_ctrl_idx, clock_gen_pkg::pin_function_idx: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 9'h000;
      w_data_q <= 16'h0000;
      w_strb_q <= 2'b00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clock_gen_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata[15:0];
        w_strb_q <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? clock_gen_pkg::resp_okay : clock_gen_pkg::resp_slverr;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] st);
    merge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr2_q <= clock_gen_pkg::power_control_two_rst;
      clk1_q <= clock_gen_pkg::clock_config_one_rst;
      clk4_q <= clock_gen_pkg::clock_config_four_rst;
      loop1_q <= clock_gen_pkg::loop_control_one_rst;
      loop2_q <= clock_gen_pkg::loop_control_two_rst;
      loop3_q <= clock_gen_pkg::loop_control_three_rst;
      loop4_q <= clock_gen_pkg::loop_control_four_rst;
      loop5_q <= clock_gen_pkg::loop_control_five_rst;
      audio_q <= clock_gen_pkg::audio_clock_ctrl_rst;
      pinf_q <= clock_gen_pkg::pin_function_rst;
    end else if (wr_go) begin
      case (wr_idx)
        clock_gen_pkg::power_control_two_idx: pwr2_q <= merge(pwr2_q, w_data_q, w_strb_q);
        clock_gen_pkg::clock_config_one_idx: clk1_q <= merge(clk1_q, w_data_q, w_strb_q);
        clock_gen_pkg::clock_config_four_idx: clk4_q <= merge(clk4_q, w_data_q, w_strb_q);
        clock_gen_pkg::loop_control_one_idx: loop1_q <= merge(loop1_q, w_data_q, w_strb_q);
        clock_gen_pkg::loop_control_two_idx: loop2_q <= merge(loop2_q, w_data_q, w_strb_q);
        clock_gen_pkg::loop_control_three_idx: loop3_q <= merge(loop3_q, w_data_q, w_strb_q);
        clock_gen_pkg::loop_control_four_idx: loop4_q <= merge(loop4_q, w_data_q, w_strb_q);
        clock_gen_pkg::loop_control_five_idx: loop5_q <= merge(loop5_q, w_data_q, w_strb_q);
        clock_gen_pkg::audio_clock_ctrl_idx: audio_q <= merge(audio_q, w_data_q, w_strb_q);
        clock_gen_pkg::pin_function_idx: pinf_q <= merge(pinf_q, w_data_q, w_strb_q);
        default: pwr2_q <= pwr2_q;
      endcase
    end
  end

  // Read channel.
  logic [7:0] rd_idx;
  logic [15:0] status_word;
  assign rd_idx = {1'b0, s_axi_araddr[8:2]};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= clock_gen_pkg::unmapped_data;
      s_axi_rresp <= clock_gen_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= clock_gen_pkg::resp_okay;
      case (rd_idx)
        clock_gen_pkg::power_control_two_idx: s_axi_rdata <= {16'h0000, pwr2_q};
        clock_gen_pkg::clock_config_one_idx: s_axi_rdata <= {16'h0000, clk1_q};
        clock_gen_pkg::clock_config_four_idx: s_axi_rdata <= {16'h0000, clk4_q};
        clock_gen_pkg::loop_control_one_idx: s_axi_rdata <= {16'h0000, loop1_q};
        clock_gen_pkg::loop_control_two_idx: s_axi_rdata <= {16'h0000, loop2_q};
        clock_gen_pkg::loop_control_three_idx: s_axi_rdata <= {16'h0000, loop3_q};
        clock_gen_pkg::loop_control_four_idx: s_axi_rdata <= {16'h0000, loop4_q};
        clock_gen_pkg::loop_control_five_idx: s_axi_rdata <= {16'h0000, loop5_q};
        clock_gen_pkg::audio_clock_ctrl_idx: s_axi_rdata <= {16'h0000, audio_q};
        clock_gen_pkg::pin_function_idx: s_axi_rdata <= {16'h0000, pinf_q};
        clock_gen_pkg::status_idx: s_axi_rdata <= {16'h0000, status_word};
        default: begin
          s_axi_rdata <= clock_gen_pkg::unmapped_data;
          s_axi_rresp <= clock_gen_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin clock divider, counted in half cycles of the system clock.
  logic [3:0] pdiv;
  logic [4:0] half_q;
  logic [4:0] half_len;
  logic pin_clk_q, pin_en;
  assign pdiv = clk1_q[clock_gen_pkg::pin_clock_divider_lsb +: 4];
  assign pin_en = pwr2_q[clock_gen_pkg::pin_clock_enable_bit];

  // Half period lengths in clk cycles, one per half system clock; 5.5 uses 5 and 6.
  logic alt_q;
  always_comb begin
    case (pdiv)
      4'h1: half_len = 5'd2;
      4'h2: half_len = 5'd3;
      4'h3: half_len = 5'd4;
      4'h4: half_len = alt_q ? 5'd6 : 5'd5;
      4'h5: half_len = 5'd6;
      4'h6: half_len = 5'd8;
      4'h7: half_len = 5'd12;
      4'h8: half_len = 5'd16;
      default: half_len = 5'd1;
    endcase
  end

  logic [1:0] phase_q;
  always_ff @(posedge clk) begin
    if (srst || !pin_en) begin
      half_q <= 5'd0;
      pin_clk_q <= 1'b0;
      alt_q <= 1'b0;
      phase_q <= 2'd0;
    end else if (half_q + 5'd1 >= half_len) begin
      half_q <= 5'd0;
      pin_clk_q <= !pin_clk_q;
      // Only 5.5 uses the long half, in two of every four halves.
      phase_q <= phase_q + 2'd1;
      alt_q <= (pdiv == 4'h4) ? (phase_q == 2'd1 || phase_q == 2'd2) : 1'b0;
    end else begin
      half_q <= half_q + 5'd1;
    end
  end

  logic pin_out_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out_q <= 1'b0;
    end else begin
      // Code 0 passes the system clock level toggle each cycle.
      pin_out_q <= pin_en && pinf_q[1:0] == clock_gen_pkg::pin_func_clock &&
                   ((pdiv == 4'h0) ? !pin_out_q : pin_clk_q);
    end
  end
  assign general_pin_one = pin_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timeout clock: 256 kHz tick, then /1024 base, then scaling.
  logic [6:0] slow_q;
  logic slow_tick;
  assign slow_tick = slow_q == 7'(clock_gen_pkg::slow_tick_cycles - 1);
  logic to_en, to_full, to_x4, to_d16;
  assign to_en = clk1_q[clock_gen_pkg::timeout_clock_enable_bit];
  assign to_full = clk1_q[clock_gen_pkg::timeout_half_rate_select_bit];
  assign to_x4 = clk4_q[clock_gen_pkg::timeout_times_four_bit];
  assign to_d16 = clk4_q[clock_gen_pkg::timeout_divide_sixteen_bit];

  // Half period in 256 kHz ticks: 512 base, x4 /4, full /1 half x2, /16 x16.
  logic [14:0] to_half;
  always_comb begin
    to_half = 15'(clock_gen_pkg::timeout_base_div / 2);
    if (to_x4) to_half = 15'(clock_gen_pkg::timeout_x4_half_periods / 2);
    if (!to_full) to_half = {to_half[13:0], 1'b0};
    if (to_d16) to_half = {to_half[10:0], 4'h0};
  end

  logic [14:0] to_cnt_q;
  logic to_clk_q;
  always_ff @(posedge clk) begin
    if (srst || !to_en) begin
      slow_q <= 7'd0;
      to_cnt_q <= 15'd0;
      to_clk_q <= 1'b0;
    end else begin
      slow_q <= slow_tick ? 7'd0 : slow_q + 7'd1;
      if (slow_tick) begin
        if (to_cnt_q + 15'd1 >= to_half) begin
          to_cnt_q <= 15'd0;
          to_clk_q <= !to_clk_q;
        end else begin
          to_cnt_q <= to_cnt_q + 15'd1;
        end
      end
    end
  end
  assign timeout_clock = to_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages two and three agree.
  logic [2:0] bck_s, frm_s, mck_s;
  logic bck_lvl_q, frm_lvl_q, mck_lvl_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      bck_s <= 3'b000;
      frm_s <= 3'b000;
      mck_s <= 3'b000;
      bck_lvl_q <= 1'b0;
      frm_lvl_q <= 1'b0;
      mck_lvl_q <= 1'b0;
    end else begin
      bck_s <= {bck_s[1:0], ext_bit_clock};
      frm_s <= {frm_s[1:0], ext_frame_clock};
      mck_s <= {mck_s[1:0], master_clock_in};
      if (bck_s[1] == bck_s[2]) bck_lvl_q <= bck_s[2];
      if (frm_s[1] == frm_s[2]) frm_lvl_q <= frm_s[2];
      if (mck_s[1] == mck_s[2]) mck_lvl_q <= mck_s[2];
    end
  end

  // Master bit clock and frame clock.
  logic master_mode, ext_bclk;
  logic [7:0] bclk_div, frame_half;
  logic [7:0] bc_cnt_q, fr_cnt_q;
  logic bc_q, fr_q, bc_prev_q, bc_src;
  assign master_mode = audio_q[clock_gen_pkg::master_mode_bit];
  assign ext_bclk = audio_q[clock_gen_pkg::external_bit_clock_bit];
  assign bclk_div = {2'b00, audio_q[clock_gen_pkg::bit_clock_divider_lsb +: 6]};
  assign frame_half = {2'b00, audio_q[clock_gen_pkg::frame_rate_lsb +: 6]};
  assign bc_src = ext_bclk ? bck_lvl_q : bc_q;

  always_ff @(posedge clk) begin
    if (srst || !master_mode) begin
      bc_cnt_q <= 8'd0;
      bc_q <= 1'b0;
      fr_cnt_q <= 8'd0;
      fr_q <= 1'b0;
      bc_prev_q <= 1'b0;
    end else begin
      bc_prev_q <= bc_src;
      if (bc_cnt_q + 8'd1 >= bclk_div) begin
        bc_cnt_q <= 8'd0;
        bc_q <= !bc_q;
      end else begin
        bc_cnt_q <= bc_cnt_q + 8'd1;
      end
      // Frame counts bit-clock falling edges; frame_half is half the frame length.
      if (bc_prev_q && !bc_src) begin
        if (fr_cnt_q + 8'd1 >= frame_half) begin
          fr_cnt_q <= 8'd0;
          fr_q <= !fr_q;
        end else begin
          fr_cnt_q <= fr_cnt_q + 8'd1;
        end
      end
    end
  end
  assign bit_clock_out = bc_q;
  assign frame_clock_out = fr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Loop configuration and derived multiplier terms.
  logic frac_on;
  assign frac_on = loop1_q[clock_gen_pkg::loop_fractional_mode_bit];
  assign loop_config.enable = loop1_q[clock_gen_pkg::loop_enable_bit];
  assign loop_config.osc_enable = loop1_q[clock_gen_pkg::loop_osc_enable_bit];
  assign loop_config.fractional_mode = frac_on;
  assign loop_config.output_divider = loop2_q[clock_gen_pkg::loop_output_divider_lsb +: 3];
  assign loop_config.reference_ratio = loop2_q[2:0];
  assign loop_config.fraction_multiplier = loop3_q;
  assign loop_config.integer_multiplier = loop4_q[clock_gen_pkg::loop_integer_multiplier_lsb +: 10];
  assign loop_config.reference_prediv = loop5_q[clock_gen_pkg::loop_reference_prediv_lsb +: 2];
  assign loop_config.reference_source = loop5_q[1:0];

  assign osc_multiplier_int = {6'h00, loop_config.integer_multiplier};
  assign osc_multiplier_frac = frac_on ? loop3_q : 16'h0000;

  // Log2 of total factor: ratio (x2^r, r capped at 4) minus prediv minus output divider.
  logic [2:0] ratio_log;
  assign ratio_log = loop_config.reference_ratio[2] ? 3'd4 : loop_config.reference_ratio;
  assign osc_total_factor_log = {6'h00, ratio_log} + 9'd16
                              - {7'h00, loop_config.reference_prediv}
                              - {6'h00, loop_config.output_divider} - 9'd1;

  // Reference selection and level.
  always_comb begin
    case (loop_config.reference_source)
      2'b00: loop_reference_level = mck_lvl_q;
      2'b01: loop_reference_level = frm_lvl_q;
      2'b10: loop_reference_level = bck_lvl_q;
      default: loop_reference_level = 1'b0;
    endcase
  end
  assign loop_reference_sel_out = {1'b0, loop_config.reference_source};

  logic running_q, free_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      running_q <= 1'b0;
      free_q <= 1'b0;
    end else begin
      running_q <= loop_config.enable;
      free_q <= loop_config.osc_enable && !loop_config.enable;
    end
  end
  assign loop_running = running_q;
  assign loop_free_running = free_q;
  assign status_word = {12'h000, free_q, running_q, to_clk_q, pin_out_q};

endmodule
`default_nettype wire

// ---- tb/clock_gen_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_gen_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Generated clocks and loop view.
  input wire logic general_pin_one,
  input wire logic timeout_clock,
  input wire logic [15:0] osc_multiplier_int,
  input wire logic [15:0] osc_multiplier_frac,
  input wire clock_gen_pkg::loop_config_t loop_config
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid &&
    !s_axi_rvalid && !general_pin_one && !timeout_clock) else $error("outputs live in reset");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  write_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_retire_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  frac_off_a: assert property (!loop_config.fractional_mode |->
    osc_multiplier_frac == 16'h0000) else $error("fraction used in integer mode");
  frac_pass_a: assert property (loop_config.fractional_mode |->
    osc_multiplier_frac == loop_config.fraction_multiplier) else $error("fraction wrong");
  int_pass_a: assert property (osc_multiplier_int ==
    {6'h00, loop_config.integer_multiplier}) else $error("integer multiplier wrong");
endmodule
`default_nettype wire

// ---- tb/ref_clock_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source #(
  parameter real mclk_half_ns = 41.0,
  parameter real bclk_half_ns = 163.0,
  parameter int frame_bits = 32
) (
  // Reference clocks toward the block.
  output logic master_clock_in,
  output logic ext_bit_clock,
  output logic ext_frame_clock
);
  int bit_cnt = 0;
  // A reference of about 12.2 MHz needs no pre-division below the 13.5 MHz limit.
  initial begin
    master_clock_in = 1'b0;
    forever #(mclk_half_ns) master_clock_in = ~master_clock_in;
  end
  initial begin
    ext_bit_clock = 1'b0;
    #7;
    forever #(bclk_half_ns) ext_bit_clock = ~ext_bit_clock;
  end
  initial ext_frame_clock = 1'b0;
  always @(negedge ext_bit_clock) begin
    bit_cnt = (bit_cnt + 1) % frame_bits;
    if (bit_cnt == 0) ext_frame_clock = ~ext_frame_clock;
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_fail++; $display("CHECK FAILED %0t %s", $time, msg); end end
module testbench;
  localparam logic [8:0] pwr_addr = {clock_gen_pkg::power_control_two_idx[6:0], 2'b00};
  localparam logic [8:0] cfg1_addr = {clock_gen_pkg::clock_config_one_idx[6:0], 2'b00};
  localparam logic [8:0] cfg4_addr = {clock_gen_pkg::clock_config_four_idx[6:0], 2'b00};
  localparam logic [8:0] pin_addr = {clock_gen_pkg::pin_function_idx[6:0], 2'b00};
  localparam logic [8:0] lc1_addr = {clock_gen_pkg::loop_control_one_idx[6:0], 2'b00};
  localparam logic [8:0] lc2_addr = {clock_gen_pkg::loop_control_two_idx[6:0], 2'b00};
  localparam logic [8:0] lc3_addr = {clock_gen_pkg::loop_control_three_idx[6:0], 2'b00};
  localparam logic [8:0] lc4_addr = {clock_gen_pkg::loop_control_four_idx[6:0], 2'b00};
  localparam logic [8:0] aud_addr = {clock_gen_pkg::audio_clock_ctrl_idx[6:0], 2'b00};
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, mclk, bclk, fclk, pin, toc, bco, fco;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lfsr_q;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int per2[9] = '{4, 8, 12, 16, 22, 24, 32, 48, 64};
  int n_fail = 0;
  int compares = 0;
  realtime t0;
  codec_clock_generation dut_u (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_bit_clock(bclk), .ext_frame_clock(fclk), .master_clock_in(mclk),
    .general_pin_one(pin), .timeout_clock(toc), .bit_clock_out(bco), .frame_clock_out(fco),
    .osc_multiplier_int(), .osc_multiplier_frac(), .osc_total_factor_log(),
    .loop_reference_sel_out(), .loop_reference_level(), .loop_config(),
    .loop_running(), .loop_free_running());
  ref_clock_source src_u (.master_clock_in(mclk), .ext_bit_clock(bclk),
    .ext_frame_clock(fclk));
  ////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bq.push_back(clock_gen_pkg::resp_okay);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [1:0] er, input logic [31:0] ed);
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pin_idle();
    repeat (64) begin
      @(posedge clk);
      `CHK(pin, 1'b0, "pin clock leaked")
    end
  endtask
  // Results are compared against the oldest expectation when they appear.
  always @(posedge clk) begin
    if (bvalid && bready) `CHK(bresp, bq.pop_front(), "write response")
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front(), "read result")
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata} = '0;
    lfsr_q = 32'h0000_0013;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(pwr_addr, clock_gen_pkg::resp_okay, 32'h0000_0000);
    rd(cfg1_addr, clock_gen_pkg::resp_okay, {16'h0000, clock_gen_pkg::clock_config_one_rst});
    rd(9'h04C, clock_gen_pkg::resp_slverr, clock_gen_pkg::unmapped_data);
    wr(pin_addr, 32'(clock_gen_pkg::pin_func_clock));
    pin_idle();
    wr(pwr_addr, 32'h0000_0800);
    wr(pin_addr, 32'h0000_0000);
    pin_idle();
    wr(pin_addr, 32'(clock_gen_pkg::pin_func_clock));
    for (int c = 0; c < 9; c++) begin
      wr(cfg1_addr, 32'(c) << clock_gen_pkg::pin_clock_divider_lsb);
      repeat (2) @(posedge pin);
      t0 = $realtime;
      repeat (2) @(posedge pin);
      `CHK(int'(($realtime - t0) / 40.0), per2[c], "pin clock period")
    end
    `CHK(toc, 1'b0, "timeout clock while disabled")
    wr(cfg1_addr, 32'h0000_C000);
    wr(cfg4_addr, 32'h0000_0880);
    @(posedge toc);
    t0 = $realtime;
    @(posedge toc);
    `CHK(int'(($realtime - t0) / 40.0), clock_gen_pkg::timeout_base_div / 4 * clock_gen_pkg::slow_tick_cycles, "timeout period")
    // The default bit-clock reference near 3 MHz takes ratio 0h; N of 30 with K of at least
    // one half keeps the oscillator between 93 and 96 MHz, output divider 2h near 12 MHz.
    wr(lc2_addr, 32'h0000_0200);
    wr(lc4_addr, 32'h0000_03C0);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(lc1_addr, 32'h0000_0000);
      wr(lc3_addr, lfsr_q | 32'h0000_8000);
      rd(lc3_addr, clock_gen_pkg::resp_okay, {16'h0000, lfsr_q[15:0] | 16'h8000});
      wr(lc1_addr, 32'h0000_0005);
    end
    // Master mode, bit clock half of 3 cycles, frame half of 2 bit clocks.
    wr(aud_addr, 32'h0000_8203);
    repeat (2) @(posedge bco);
    t0 = $realtime;
    @(posedge bco);
    `CHK(int'(($realtime - t0) / 40.0), 6, "bit clock period")
    @(posedge fco);
    t0 = $realtime;
    @(posedge fco);
    `CHK(int'(($realtime - t0) / 40.0), 24, "frame clock period")
    finish_test();
  end
endmodule
bind codec_clock_generation clock_gen_checker chk_u (.clk(clk), .srst(srst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .general_pin_one(general_pin_one),
  .timeout_clock(timeout_clock), .osc_multiplier_int(osc_multiplier_int),
  .osc_multiplier_frac(osc_multiplier_frac), .loop_config(loop_config));
`default_nettype wire
